// >>> rtl/ipcb_bank.sv
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "ipcb_consts.svh"
// Function
// R1 - each input has a 4-bit priority where a smaller nonzero value ranks higher.
// R2 - a zero priority removes the input from automatic selection, one to fifteen is valid.
// R3 - with bank select clear, accesses reach the main timing path copy.
// R4 - with bank select set, accesses reach the auxiliary timing path copy.
// R5 - odd input sits in bits 3:0 and the following even input in bits 7:4, read/write.
// R6 - reset loads 0x54/0x00 for inputs 3/4 and 0x76/0x76 for inputs 5/6.
// R7 - each path presents its priorities and which inputs are eligible.
module ipcb_bank #(
   parameter int NUM_IN = 4
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rstn,
   // register port
   input wire ipcb_pkg::ipcb_req_t i_req,
   output logic [7:0] o_rdata,
   // per-path priorities
   output var ipcb_pkg::ipcb_prio_t o_main_prio,
   output var ipcb_pkg::ipcb_prio_t o_aux_prio,
   // per-path eligibility, bit 0 is input three
   output logic [NUM_IN-1:0] o_main_elig,
   output logic [NUM_IN-1:0] o_aux_elig,
   // current bank select
   output logic o_path_bank_select
);
   import ipcb_pkg::*;

   // ************************************
   // parameter check
   // ************************************
   // the field struct carries one nibble per input, nothing else fits
   if (NUM_IN * `IPCB_FLD_W != $bits(ipcb_prio_t)) begin : g_bad_num_in
      $error("NUM_IN does not match the field struct");
   end

   // ************************************
   // storage
   // ************************************
   // main timing path copies
   logic [7:0] p34_main_q;
   logic [7:0] p56_main_q;
   // aux timing path copies
   logic [7:0] p34_aux_q;
   logic [7:0] p56_aux_q;
   // path bank select bit
   logic bank_q;
   // read data register
   logic [7:0] rdata_q;
   // eligibility registers
   logic [NUM_IN-1:0] main_elig_q;
   logic [NUM_IN-1:0] aux_elig_q;

   // ************************************
   // decode helpers
   // ************************************
   // word index match
   function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
      hit = (a == idx);
   endfunction

   // a field takes part in selection only when nonzero
   function automatic logic nonzero(input logic [`IPCB_FLD_W-1:0] f);
      nonzero = (f != '0);
   endfunction

   // ************************************
   // address and bank decode
   // ************************************
   // register hits
   wire hit34 = hit(i_req.addr, `IPCB_IDX_PAIR34);
   wire hit56 = hit(i_req.addr, `IPCB_IDX_PAIR56);
   wire hitbs = hit(i_req.addr, `IPCB_IDX_BANKSEL);

   // bank steering of writes
   wire wr_main = i_req.wr & ~bank_q; // R3
   wire wr_aux = i_req.wr & bank_q; // R4
   wire we34_main = wr_main & hit34; // R3
   wire we56_main = wr_main & hit56; // R3
   wire we34_aux = wr_aux & hit34; // R4
   wire we56_aux = wr_aux & hit56; // R4
   wire we_bs = i_req.wr & hitbs;

   // bank steering of reads
   wire [7:0] sel34 = bank_q ? p34_aux_q : p34_main_q; // R3 R4
   wire [7:0] sel56 = bank_q ? p56_aux_q : p56_main_q; // R3 R4
   wire [7:0] bs_word = 8'(bank_q) << `IPCB_BANKSEL_BIT;

   // read selection, unmapped words read zero
   wire [7:0] rd_mux = hit34 ? sel34 : hit56 ? sel56 : hitbs ? bs_word : 8'h00; // R5
   // read data drops back to zero outside a read
   wire [7:0] rdata_d = i_req.rd ? rd_mux : 8'h00;

   // whole bank of each path, odd input in the low nibble
   wire [15:0] main_w = {p56_main_q, p34_main_q}; // R5
   wire [15:0] aux_w = {p56_aux_q, p34_aux_q}; // R5

   // ************************************
   // priority registers
   // ************************************
   // main copy of inputs three and four
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         p34_main_q <= `IPCB_RST_34_MAIN; // R6
      end else if (we34_main) begin
         p34_main_q <= i_req.wdata; // R3 R5
      end
   end

   // main copy of inputs five and six
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         p56_main_q <= `IPCB_RST_56_MAIN; // R6
      end else if (we56_main) begin
         p56_main_q <= i_req.wdata; // R3 R5
      end
   end

   // aux copy of inputs three and four
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         p34_aux_q <= `IPCB_RST_34_AUX; // R6
      end else if (we34_aux) begin
         p34_aux_q <= i_req.wdata; // R4 R5
      end
   end

   // aux copy of inputs five and six
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         p56_aux_q <= `IPCB_RST_56_AUX; // R6
      end else if (we56_aux) begin
         p56_aux_q <= i_req.wdata; // R4 R5
      end
   end

   // ************************************
   // bank select and read data
   // ************************************
   // bank select bit, steers accesses from the next cycle on
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         bank_q <= 1'b0;
      end else if (we_bs) begin
         bank_q <= i_req.wdata[`IPCB_BANKSEL_BIT]; // R3 R4
      end
   end

   // read data one cycle after strobe
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ************************************
   // eligibility: nonzero fields only
   // ************************************
   wire [NUM_IN-1:0] main_elig_d;
   wire [NUM_IN-1:0] aux_elig_d;

   // one zero test per input and path
   genvar g;
   generate
      for (g = 0; g < NUM_IN; g++) begin : g_elig
         assign main_elig_d[g] = nonzero(main_w[g*`IPCB_FLD_W +: `IPCB_FLD_W]); // R2 R7
         assign aux_elig_d[g] = nonzero(aux_w[g*`IPCB_FLD_W +: `IPCB_FLD_W]); // R2 R7
      end
   endgenerate

   // registered so the outputs come from flops, one cycle behind the fields
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         main_elig_q <= '0;
         aux_elig_q <= '0;
      end else begin
         main_elig_q <= main_elig_d; // R2 R7
         aux_elig_q <= aux_elig_d; // R2 R7
      end
   end

   // ************************************
   // outputs
   // ************************************
   // field outputs straight from registers, odd low, even high
   assign o_main_prio = ipcb_prio_t'(main_w); // R1 R5 R7
   assign o_aux_prio = ipcb_prio_t'(aux_w); // R1 R5 R7
   // eligibility, read data and bank select from their flops
   assign o_main_elig = main_elig_q;
   assign o_aux_elig = aux_elig_q;
   assign o_rdata = rdata_q;
   assign o_path_bank_select = bank_q;

   // ************************************
   // checks
   // ************************************
   // main path writes land in the main copy
   AST_MAIN_WR: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R3
      (i_req.wr && hit34 && !o_path_bank_select) |=> (p34_main_q == $past(i_req.wdata)))
      else $error("main write lost");

   AST_MAIN_WR56: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R3
      (i_req.wr && hit56 && !o_path_bank_select) |=> (p56_main_q == $past(i_req.wdata)))
      else $error("main write to inputs five and six lost");

   // aux path writes land in the aux copy
   AST_AUX_WR: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R4
      (i_req.wr && hit56 && o_path_bank_select) |=> (p56_aux_q == $past(i_req.wdata)))
      else $error("aux write lost");

   AST_AUX_WR34: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R4
      (i_req.wr && hit34 && o_path_bank_select) |=> (p34_aux_q == $past(i_req.wdata)))
      else $error("aux write to inputs three and four lost");

   // the copy of the other path is never touched
   AST_AUX_KEEP: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R3
      (i_req.wr && !o_path_bank_select) |=> $stable(p34_aux_q) && $stable(p56_aux_q))
      else $error("aux copy disturbed");

   AST_MAIN_KEEP: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R4
      (i_req.wr && o_path_bank_select) |=> $stable(p34_main_q) && $stable(p56_main_q))
      else $error("main copy disturbed");

   // reads return the copy of the selected path
   AST_RD_34: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R3 R5
      (i_req.rd && hit34 && !o_path_bank_select) |=> (o_rdata == $past(p34_main_q)))
      else $error("read data wrong");

   AST_RD_34_AUX: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R4 R5
      (i_req.rd && hit34 && o_path_bank_select) |=> (o_rdata == $past(p34_aux_q)))
      else $error("aux read of inputs three and four wrong");

   AST_RD_56: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R3 R5
      (i_req.rd && hit56 && !o_path_bank_select) |=> (o_rdata == $past(p56_main_q)))
      else $error("main read of inputs five and six wrong");

   AST_RD_56_AUX: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R4 R5
      (i_req.rd && hit56 && o_path_bank_select) |=> (o_rdata == $past(p56_aux_q)))
      else $error("aux read of inputs five and six wrong");

   // bank select reads back in its own bit
   AST_RD_BS: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R4
      (i_req.rd && hitbs) |=> (o_rdata[`IPCB_BANKSEL_BIT] == $past(o_path_bank_select)))
      else $error("bank select read wrong");

   // a bank select write takes effect in the next cycle
   AST_BS_WR: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R3 R4
      (i_req.wr && hitbs) |=> (o_path_bank_select == $past(i_req.wdata[`IPCB_BANKSEL_BIT])))
      else $error("bank select write lost");

   // read data only stands in the cycle after a read
   AST_RD_IDLE: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R5
      !i_req.rd |=> (o_rdata == 8'h00))
      else $error("read data without read");

   // unmapped words read zero
   AST_RD_UNMAPPED: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R5
      (i_req.rd && !hit34 && !hit56 && !hitbs) |=> (o_rdata == 8'h00))
      else $error("unmapped read not zero");

   // defaults after a reset cycle
   AST_RST: assert property (@(posedge i_mclk) // R6
      !i_rstn |=> (p34_main_q == `IPCB_RST_34_MAIN) && (p34_aux_q == `IPCB_RST_34_AUX)
      && (p56_main_q == `IPCB_RST_56_MAIN) && (p56_aux_q == `IPCB_RST_56_AUX))
      else $error("reset value wrong");

   AST_RST_CTRL: assert property (@(posedge i_mclk) // R6
      !i_rstn |=> !o_path_bank_select && (o_rdata == 8'h00))
      else $error("bank select or read data not cleared by reset");

   // field map of a main write on the priority outputs
   AST_PRIO: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R5
      (i_req.wr && hit34 && !o_path_bank_select) |=>
      (o_main_prio.in3 == $past(i_req.wdata[`IPCB_LO_MSB:0]))
      && (o_main_prio.in4 == $past(i_req.wdata[`IPCB_HI_MSB:`IPCB_HI_LSB])))
      else $error("field map wrong");

   // field map of an aux write on the priority outputs
   AST_PRIO_AUX: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R4 R5
      (i_req.wr && hit56 && o_path_bank_select) |=>
      (o_aux_prio.in5 == $past(i_req.wdata[`IPCB_LO_MSB:0]))
      && (o_aux_prio.in6 == $past(i_req.wdata[`IPCB_HI_MSB:`IPCB_HI_LSB])))
      else $error("aux field map wrong");

   // eligibility follows each field one cycle later
   generate
      for (g = 0; g < NUM_IN; g++) begin : g_elig_chk
         AST_ELIG: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R2
            (o_main_prio[g*`IPCB_FLD_W +: `IPCB_FLD_W] != 4'h0) |=> o_main_elig[g])
            else $error("eligible main input not flagged");

         AST_ELIG_ZERO: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R2
            (o_main_prio[g*`IPCB_FLD_W +: `IPCB_FLD_W] == 4'h0) |=> !o_main_elig[g])
            else $error("excluded main input flagged");

         AST_ELIG_AUX: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R7
            (o_aux_prio[g*`IPCB_FLD_W +: `IPCB_FLD_W] != 4'h0) |=> o_aux_elig[g])
            else $error("aux eligibility wrong");

         AST_ELIG_AUX_ZERO: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R7
            (o_aux_prio[g*`IPCB_FLD_W +: `IPCB_FLD_W] == 4'h0) |=> !o_aux_elig[g])
            else $error("excluded aux input flagged");
      end
   endgenerate

   // eligibility is clear while reset holds
   AST_RST_ELIG: assert property (@(posedge i_mclk) // R7
      !i_rstn |=> (o_main_elig == '0) && (o_aux_elig == '0))
      else $error("eligibility not cleared by reset");

   // a write with no path bit set leaves the bank select clear
   AST_BS_CLR: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R3
      (i_req.wr && hitbs && !i_req.wdata[`IPCB_BANKSEL_BIT]) |=> !o_path_bank_select)
      else $error("bank select not cleared");

   // writes to unmapped words change no priority copy
   AST_WR_UNMAPPED: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R5
      (i_req.wr && !hit34 && !hit56) |=> $stable(main_w) && $stable(aux_w))
      else $error("unmapped write changed a priority");

   // the aux copy of inputs five and six keeps its value between writes
   AST_AUX56_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R4
      !(i_req.wr && hit56 && o_path_bank_select) |=> $stable(p56_aux_q))
      else $error("aux copy of inputs five and six changed without a write");

   // the main copy of inputs three and four keeps its value between writes
   AST_MAIN34_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R3
      !(i_req.wr && hit34 && !o_path_bank_select) |=> $stable(p34_main_q))
      else $error("main copy of inputs three and four changed without a write");
endmodule
`default_nettype wire

// >>> rtl/ipcb_consts.svh
`ifndef IPCB_CONSTS_SVH
`define IPCB_CONSTS_SVH
// register word indices on the register port
`define IPCB_IDX_PAIR34 8'h1a
`define IPCB_IDX_PAIR56 8'h1b
`define IPCB_IDX_BANKSEL 8'h4b
// bank select bit position in the source-select register
`define IPCB_BANKSEL_BIT 4
// reset values
`define IPCB_RST_34_MAIN 8'h54
`define IPCB_RST_34_AUX 8'h00
`define IPCB_RST_56_MAIN 8'h76
`define IPCB_RST_56_AUX 8'h76
// field layout
`define IPCB_LO_MSB 3
`define IPCB_HI_LSB 4
`define IPCB_HI_MSB 7
`define IPCB_FLD_W 4
`endif

// >>> rtl/ipcb_pkg.sv
`default_nettype none
package ipcb_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ipcb_req_t;
   typedef struct packed {
      logic [3:0] in6;
      logic [3:0] in5;
      logic [3:0] in4;
      logic [3:0] in3;
   } ipcb_prio_t;
endpackage
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import ipcb_pkg::*;
   logic i_mclk = 1'b0;
   logic i_rstn = 1'b0;
   ipcb_req_t i_req = '0;
   logic [7:0] o_rdata;
   ipcb_prio_t o_main_prio;
   ipcb_prio_t o_aux_prio;
   logic [3:0] o_main_elig;
   logic [3:0] o_aux_elig;
   logic o_path_bank_select;
   int failures = 0;
   int tests_run = 0;
   // 40 MHz clock
   always #12.5 i_mclk = ~i_mclk;
   ipcb_bank #(.NUM_IN(4)) i_ipcb_bank (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_req(i_req),
      .o_rdata(o_rdata), .o_main_prio(o_main_prio), .o_aux_prio(o_aux_prio),
      .o_main_elig(o_main_elig), .o_aux_elig(o_aux_elig),
      .o_path_bank_select(o_path_bank_select));
   // ****************
   // tasks
   // ****************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one strobe cycle, then idle; rdata is valid right after
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_req <= '{addr: a, wdata: d, wr: w, rd: ~w};
      @(posedge i_mclk);
      i_req <= '0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      acc(1'b0, a, 8'h00);
      chk({8'h00, o_rdata}, {8'h00, exp});
   endtask
   // per-path outputs, eligibility lags by a cycle
   task automatic outs(input logic [15:0] mp, input logic [15:0] ap, input logic [7:0] el);
      repeat (2) @(posedge i_mclk);
      #1;
      chk(o_main_prio, mp);
      chk(o_aux_prio, ap);
      chk({8'h00, o_main_elig, o_aux_elig}, {8'h00, el});
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ****************
   // tests
   // ****************
   // watchdog, about four times the length of the tests
   initial begin
      #6000;
      failures++;
      test_done;
   end
   initial begin
      repeat (4) @(posedge i_mclk);
      i_rstn <= 1'b1;
      outs(16'h7654, 16'h7600, 8'hfc);
      rd(8'h1a, 8'h54);
      rd(8'h1b, 8'h76);
      acc(1'b1, 8'h4b, 8'h10);
      rd(8'h4b, 8'h10);
      chk({15'h0000, o_path_bank_select}, 16'h0001);
      @(posedge i_mclk);
      #1;
      chk({8'h00, o_rdata}, 16'h0000);
      rd(8'h1a, 8'h00);
      rd(8'h1b, 8'h76);
      acc(1'b1, 8'h1a, 8'h21);
      rd(8'h1a, 8'h21);
      acc(1'b1, 8'h1b, 8'h0f);
      outs(16'h7654, 16'h0f21, 8'hf7);
      acc(1'b1, 8'h4b, 8'h00);
      rd(8'h4b, 8'h00);
      chk({15'h0000, o_path_bank_select}, 16'h0000);
      acc(1'b1, 8'h1a, 8'ha0);
      rd(8'h1a, 8'ha0);
      rd(8'h1b, 8'h76);
      acc(1'b1, 8'h1b, 8'h98);
      rd(8'h1b, 8'h98);
      outs(16'h98a0, 16'h0f21, 8'he7);
      acc(1'b1, 8'h00, 8'hff);
      rd(8'h00, 8'h00);
      // reset in mid-run restores the defaults and the main bank
      @(posedge i_mclk);
      i_rstn <= 1'b0;
      repeat (4) @(posedge i_mclk);
      i_rstn <= 1'b1;
      outs(16'h7654, 16'h7600, 8'hfc);
      rd(8'h4b, 8'h00);
      rd(8'h1a, 8'h54);
      test_done;
   end
endmodule
`default_nettype wire
